/* File: common/sep_pkg.sv */
// Purpose: Shared constants and types for the serial EEPROM command port.
// Assumes: A single 40 MHz system clock samples the serial pins.
// Notes:   Array is 64 words of 16 bits, or 128 bytes in byte organization.
package sep_pkg;

    // ========================================
    // Clock and timing
    // ========================================
    localparam int unsigned CLOCK_PERIOD_NS = 25;
    localparam int unsigned PROGRAM_CYCLE_TIME_MS = 10;
    localparam int unsigned POWERUP_TO_READ_WAIT_MS = 1;
    // Longest time, so round down
    localparam int unsigned PROGRAM_CYCLE_CYCLES = (PROGRAM_CYCLE_TIME_MS * 1000000) / CLOCK_PERIOD_NS;
    // Host side wait only; the device keeps no counter for it
    localparam int unsigned POWERUP_TO_READ_CYCLES = (POWERUP_TO_READ_WAIT_MS * 1000000) / CLOCK_PERIOD_NS;
    localparam int unsigned TIMER_W = 19;

    // ========================================
    // Array geometry and frame lengths
    // ========================================
    localparam int unsigned WORDS = 64;
    localparam int unsigned WORD_W = 16;
    localparam int unsigned HDR_W = 9;
    localparam int unsigned CNT_W = 5;
    localparam logic [4:0] HDR_BITS_WORD = 5'h08;
    localparam logic [4:0] HDR_BITS_BYTE = 5'h09;
    localparam logic [4:0] DATA_BITS_WORD = 5'h10;
    localparam logic [4:0] DATA_BITS_BYTE = 5'h08;

    // ========================================
    // Opcodes and extended selectors
    // ========================================
    localparam logic [1:0] OPC_READ = 2'h2;
    localparam logic [1:0] OPC_ERASE = 2'h3;
    localparam logic [1:0] OPC_WRITE = 2'h1;
    localparam logic [1:0] OPC_EXT = 2'h0;
    localparam logic [1:0] EXT_ENABLE = 2'h3;
    localparam logic [1:0] EXT_DISABLE = 2'h0;
    localparam logic [1:0] EXT_CLEAR_ALL = 2'h2;
    localparam logic [1:0] EXT_FILL_ALL = 2'h1;

    typedef logic [TIMER_W-1:0] sep_timer_t;
    typedef logic [CNT_W-1:0] sep_cnt_t;

    // Gray along idle, command, data, armed, program
    typedef enum logic [2:0] {
        S_IDLE = 3'h0,
        S_CMD = 3'h1,
        S_DATA = 3'h3,
        S_ARMED = 3'h2,
        S_PROG = 3'h6,
        S_READ = 3'h4
    } sep_phase_t;

    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_WRITE = 3'h1,
        OP_ERASE = 3'h2,
        OP_FILL_ALL = 3'h3,
        OP_CLEAR_ALL = 3'h4
    } sep_op_t;

    typedef struct packed {
        sep_phase_t phase;
        logic sclk_prev;
        logic cs_prev;
        logic [CNT_W-1:0] cnt;
        logic [HDR_W-1:0] hdr;
        logic [WORD_W-1:0] data;
        logic [6:0] addr;
        logic byte_mode;
        sep_op_t op;
        logic wen;
        logic [TIMER_W-1:0] timer;
        logic stat_en;
        logic rel_pend;
        logic dout;
        logic doe;
        logic [WORDS-1:0][WORD_W-1:0] mem;
    } sep_state_t;

    // Write disabled, outputs released, array erased at power-up
    localparam sep_state_t STATE_RESET = '{
        phase: S_IDLE, sclk_prev: 1'b0, cs_prev: 1'b0, cnt: '0, hdr: '0, data: '0,
        addr: '0, byte_mode: 1'b0, op: OP_NONE, wen: 1'b0, timer: '0, stat_en: 1'b0,
        rel_pend: 1'b0, dout: 1'b0, doe: 1'b0, mem: '1};

endpackage : sep_pkg

/* File: hw/sep_sync.sv */
// Purpose: Two-stage synchroniser for the asynchronous serial pins.
// Assumes: Each bit is an independent level from outside the clock domain.
// Notes:   Only the second stage is visible to the rest of the logic.
module sep_sync #(
    parameter int unsigned W = 4
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    // ========================================
    // Synchroniser chain
    // ========================================
    typedef struct packed {
        logic [W-1:0] stage1;
        logic [W-1:0] stage2;
    } sep_sync_t;

    sep_sync_t sync_reg;
    sep_sync_t sync_next;

    // First stage feeds the second and nothing else
    always_comb
    begin
        sync_next.stage1 = async_in;
        sync_next.stage2 = sync_reg.stage1;
    end

    // Both stages reset low
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            sync_reg <= '0;
        end
        else
        begin
            sync_reg <= sync_next;
        end
    end

    assign sync_out = sync_reg.stage2;

endmodule : sep_sync

/* File: hw/sep_port.sv */
// Purpose: Command decoder, status output and self-timed array update of a serial EEPROM.
// Assumes: The serial clock is far slower than the 40 MHz system clock.
// Notes:   All pins pass two flip-flops, so pin edges are seen three clocks late.

// Function
// - Input bits are taken on each rising serial clock edge.
// - Frame is start one, two-bit opcode, address, then data for writes.
// - Seven commands; header nine bits wide, ten in byte organization.
// - Output driven only for read data or program status, else released.
// - With select high after a program start, low means busy, high ready.
// - A dummy one releases status on the following serial clock fall.
// - Read sends a leading zero, then the word most significant first.
// - Read output bits change on rising serial clock edges.
// - Select falling after a full write starts the timed clear and store.
// - A started program cycle completes with no serial clock at all.
// - Writes clear the location first; no separate erase needed.
// - Erase on select fall sets every bit of that location to one.
// - Device powers up write disabled; enable is needed before programming.
// - Enable state persists until power loss or a disable command.
// - While disabled, write, fill, erase and clear commands change nothing.
// - Reads return stored data whether writes are enabled or not.
// - Clear-all on select fall sets every array bit to one.
// - Fill-all on select fall stores the data word in every location.
// - Select must fall before the next rising clock, else nothing programs.
// - Each program or erase cycle ends within ten milliseconds, then ready.
// - Opcodes: 10 read, 11 erase, 01 write, 00 extended by address top.
// - Width select high or open gives words, low gives bytes.
module sep_port #(
    parameter int unsigned PROG_CYCLES = sep_pkg::PROGRAM_CYCLE_CYCLES
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic chip_select,
    input wire logic serial_clock_in,
    input wire logic serial_in_line,
    input wire logic word_width_select,
    output logic serial_out_line,
    output logic serial_out_oe
);

    // ========================================
    // Pin synchronisation
    // ========================================
    logic [3:0] pins_sync;
    logic cs_s;
    logic sclk_s;
    logic sdin_s;
    logic wsel_s;

    sep_sync #(
        .W(4)
    ) u_sync (
        .clock(clock),
        .rstn(rstn),
        .async_in({chip_select, serial_clock_in, serial_in_line, word_width_select}),
        .sync_out(pins_sync)
    );

    // Pull-up on the width pin is outside; high means word organization
    assign {cs_s, sclk_s, sdin_s, wsel_s} = pins_sync;

    // ========================================
    // State and edge terms
    // ========================================
    sep_pkg::sep_state_t q;
    sep_pkg::sep_state_t d;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;

    assign sclk_rise = sclk_s & ~q.sclk_prev;
    assign sclk_fall = ~sclk_s & q.sclk_prev;
    assign cs_fall = ~cs_s & q.cs_prev;

    // Pins come straight from flip-flops
    assign serial_out_line = q.dout;
    assign serial_out_oe = q.doe;

    // ========================================
    // Next state
    // ========================================
    always_comb
    begin
        logic byte_now;
        logic [4:0] hdr_len;
        logic [4:0] dat_len;
        logic [8:0] hdr_n;
        logic [1:0] opc;
        logic [1:0] ext;
        logic [6:0] adr;
        logic [5:0] idx;
        byte_now = ~wsel_s;
        hdr_len = byte_now ? sep_pkg::HDR_BITS_BYTE : sep_pkg::HDR_BITS_WORD;
        dat_len = q.byte_mode ? sep_pkg::DATA_BITS_BYTE : sep_pkg::DATA_BITS_WORD;
        hdr_n = {q.hdr[7:0], sdin_s};
        opc = byte_now ? hdr_n[8:7] : hdr_n[7:6];
        ext = byte_now ? hdr_n[6:5] : hdr_n[5:4];
        adr = byte_now ? hdr_n[6:0] : {1'b0, hdr_n[5:0]};
        idx = byte_now ? adr[6:1] : adr[5:0];
        d = q;
        d.sclk_prev = sclk_s;
        d.cs_prev = cs_s;

        // Status report and dummy-one release share idle and program phases
        if (q.stat_en && (q.phase == sep_pkg::S_IDLE || q.phase == sep_pkg::S_PROG) && cs_s)
        begin
            d.doe = 1'b1;
            d.dout = (q.phase == sep_pkg::S_IDLE);
            if (sclk_rise && sdin_s)
            begin
                d.rel_pend = 1'b1;
            end
            if (sclk_fall && q.rel_pend)
            begin
                d.stat_en = 1'b0;
                d.doe = 1'b0;
                d.rel_pend = 1'b0;
            end
        end

        if (!cs_s)
        begin
            // Deselect releases the line and drops unfinished frames
            d.doe = 1'b0;
            d.rel_pend = 1'b0;
            case (q.phase)
                sep_pkg::S_CMD, sep_pkg::S_DATA, sep_pkg::S_READ:
                begin
                    d.phase = sep_pkg::S_IDLE;
                end
                sep_pkg::S_ARMED:
                begin
                    // Only a fall inside the window with a live op starts a cycle
                    if (cs_fall && q.op != sep_pkg::OP_NONE)
                    begin
                        d.phase = sep_pkg::S_PROG;
                        d.timer = sep_pkg::sep_timer_t'(PROG_CYCLES - 1);
                        d.stat_en = 1'b1;
                    end
                    else
                    begin
                        d.phase = sep_pkg::S_IDLE;
                    end
                end
                default:
                begin
                    d.phase = q.phase;
                end
            endcase
        end
        else
        begin
            case (q.phase)
                sep_pkg::S_IDLE:
                begin
                    // A pending status report consumes the dummy one instead
                    if (sclk_rise && sdin_s && !q.stat_en)
                    begin
                        d.phase = sep_pkg::S_CMD;
                        d.cnt = '0;
                        d.hdr = '0;
                    end
                end
                sep_pkg::S_CMD:
                begin
                    if (sclk_rise)
                    begin
                        d.hdr = hdr_n;
                        d.cnt = sep_pkg::sep_cnt_t'(q.cnt + 5'h01);
                        if (q.cnt == sep_pkg::sep_cnt_t'(hdr_len - 5'h01))
                        begin
                            d.cnt = '0;
                            d.addr = adr;
                            d.byte_mode = byte_now;
                            d.data = '0;
                            d.phase = sep_pkg::S_ARMED;
                            d.op = sep_pkg::OP_NONE;
                            // Decode gated by the enable latch, except read, enable and disable
                            case (opc)
                                sep_pkg::OPC_READ:
                                begin
                                    d.phase = sep_pkg::S_READ;
                                    d.doe = 1'b1;
                                    d.dout = 1'b0;
                                    d.data = byte_now ? (adr[0] ? {q.mem[idx][15:8], 8'h00} :
                                        {q.mem[idx][7:0], 8'h00}) : q.mem[idx];
                                end
                                sep_pkg::OPC_WRITE:
                                begin
                                    d.phase = sep_pkg::S_DATA;
                                    d.op = q.wen ? sep_pkg::OP_WRITE : sep_pkg::OP_NONE;
                                end
                                sep_pkg::OPC_ERASE:
                                begin
                                    d.op = q.wen ? sep_pkg::OP_ERASE : sep_pkg::OP_NONE;
                                end
                                default:
                                begin
                                    case (ext)
                                        sep_pkg::EXT_ENABLE: d.wen = 1'b1;
                                        sep_pkg::EXT_DISABLE: d.wen = 1'b0;
                                        sep_pkg::EXT_CLEAR_ALL:
                                            d.op = q.wen ? sep_pkg::OP_CLEAR_ALL : sep_pkg::OP_NONE;
                                        default:
                                        begin
                                            d.phase = sep_pkg::S_DATA;
                                            d.op = q.wen ? sep_pkg::OP_FILL_ALL : sep_pkg::OP_NONE;
                                        end
                                    endcase
                                end
                            endcase
                        end
                    end
                end
                sep_pkg::S_DATA:
                begin
                    if (sclk_rise)
                    begin
                        d.data = {q.data[14:0], sdin_s};
                        d.cnt = sep_pkg::sep_cnt_t'(q.cnt + 5'h01);
                        if (q.cnt == sep_pkg::sep_cnt_t'(dat_len - 5'h01))
                        begin
                            d.phase = sep_pkg::S_ARMED;
                        end
                    end
                end
                sep_pkg::S_ARMED:
                begin
                    // A rising clock before deselect closes the window
                    if (sclk_rise)
                    begin
                        d.op = sep_pkg::OP_NONE;
                    end
                end
                sep_pkg::S_READ:
                begin
                    d.doe = 1'b1;
                    // Last bit holds until deselect; no sequential read
                    if (sclk_rise && q.cnt != dat_len)
                    begin
                        d.dout = q.data[15];
                        d.data = {q.data[14:0], 1'b0};
                        d.cnt = sep_pkg::sep_cnt_t'(q.cnt + 5'h01);
                    end
                end
                default:
                begin
                    d.phase = q.phase;
                end
            endcase
        end

        // Self-timed cycle runs from the system clock, not the serial clock
        if (q.phase == sep_pkg::S_PROG)
        begin
            if (q.timer == '0)
            begin
                d.phase = sep_pkg::S_IDLE;
                case (q.op)
                    sep_pkg::OP_WRITE:
                    begin
                        // Whole target overwritten, so the old bits never leak
                        if (q.byte_mode && q.addr[0])
                            d.mem[q.addr[6:1]][15:8] = q.data[7:0];
                        else if (q.byte_mode)
                            d.mem[q.addr[6:1]][7:0] = q.data[7:0];
                        else
                            d.mem[q.addr[5:0]] = q.data;
                    end
                    sep_pkg::OP_ERASE:
                    begin
                        if (q.byte_mode && q.addr[0])
                            d.mem[q.addr[6:1]][15:8] = 8'hFF;
                        else if (q.byte_mode)
                            d.mem[q.addr[6:1]][7:0] = 8'hFF;
                        else
                            d.mem[q.addr[5:0]] = 16'hFFFF;
                    end
                    sep_pkg::OP_FILL_ALL:
                    begin
                        for (int i = 0; i < sep_pkg::WORDS; i++)
                        begin
                            d.mem[i] = q.byte_mode ? {q.data[7:0], q.data[7:0]} : q.data;
                        end
                    end
                    sep_pkg::OP_CLEAR_ALL:
                    begin
                        d.mem = '1;
                    end
                    default:
                    begin
                        d.mem = q.mem;
                    end
                endcase
            end
            else
            begin
                d.timer = sep_pkg::sep_timer_t'(q.timer - 1'b1);
            end
        end
    end

    // ========================================
    // State register
    // ========================================
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            q <= sep_pkg::STATE_RESET;
        end
        else
        begin
            q <= d;
        end
    end

    // ========================================
    // Checks
    // ========================================
    a_oe_read_status: assert property (
        @(posedge clock) disable iff (!rstn)
        q.doe |-> (q.phase == sep_pkg::S_READ || q.stat_en))
        else $error("output driven outside read or status");

    a_read_dummy_zero: assert property (
        @(posedge clock) disable iff (!rstn)
        $rose(q.phase == sep_pkg::S_READ) |-> (q.doe && !q.dout && $past(sclk_rise)))
        else $error("read did not start with a driven zero");

    a_busy_reads_low: assert property (
        @(posedge clock) disable iff (!rstn)
        (q.phase == sep_pkg::S_PROG && q.doe) |-> !q.dout)
        else $error("status high while cycle still running");

    a_enable_by_cmd: assert property (
        @(posedge clock) disable iff (!rstn)
        $changed(q.wen) |-> ($past(sclk_rise) && $past(q.phase) == sep_pkg::S_CMD))
        else $error("enable latch moved without a command");

    a_disabled_no_op: assert property (
        @(posedge clock) disable iff (!rstn)
        ($past(q.phase) == sep_pkg::S_CMD && q.phase == sep_pkg::S_ARMED && !q.wen) |-> q.op == sep_pkg::OP_NONE)
        else $error("operation armed while write disabled");

    a_prog_on_deselect: assert property (
        @(posedge clock) disable iff (!rstn)
        $rose(q.phase == sep_pkg::S_PROG) |-> ($past(cs_fall) && q.stat_en && q.op != sep_pkg::OP_NONE))
        else $error("program cycle started without deselect");

    a_prog_bounded: assert property (
        @(posedge clock) disable iff (!rstn)
        (q.phase == sep_pkg::S_PROG && q.timer == '0) |=> (q.phase == sep_pkg::S_IDLE && q.timer == '0))
        else $error("program cycle overran its time");

    a_prog_no_sclk: assert property (
        @(posedge clock) disable iff (!rstn)
        (q.phase == sep_pkg::S_PROG && q.timer != '0) |=>
            (q.phase == sep_pkg::S_PROG && q.timer == $past(q.timer) - 1'b1))
        else $error("program cycle did not count down");

    a_status_release: assert property (
        @(posedge clock) disable iff (!rstn)
        $fell(q.stat_en) |-> ($past(sclk_fall) && !q.doe))
        else $error("status released away from a clock fall");

    a_abandon_frame: assert property (
        @(posedge clock) disable iff (!rstn)
        (cs_fall && (q.phase == sep_pkg::S_CMD || q.phase == sep_pkg::S_DATA)) |=> q.phase == sep_pkg::S_IDLE)
        else $error("partial frame not abandoned");

    a_missed_window: assert property (
        @(posedge clock) disable iff (!rstn)
        (q.phase == sep_pkg::S_ARMED && sclk_rise && cs_s) |=> (q.op == sep_pkg::OP_NONE))
        else $error("late deselect still armed an operation");

endmodule : sep_port

/* File: verif/sep_host.sv */
// Purpose: Host model that drives the serial pins of the EEPROM command port.
// Assumes: Pins change 2 ns after a rising system clock edge.
// Notes:   A released output reads as the inverse of its last level.
module sep_host (
    input wire logic clock,
    output logic chip_select,
    output logic serial_clock_in,
    output logic serial_in_line,
    input wire logic serial_out_line,
    input wire logic serial_out_oe,
    output logic res_valid,
    output logic [16:0] res_val
);
    timeunit 1ns;
    timeprecision 100ps;
    logic seen;
    logic [16:0] st;
    // ========================================
    // Line view
    // ========================================
    // No pull on the line, so a floating output must not look stable
    assign seen = serial_out_oe ? serial_out_line : ~serial_out_line;
    assign st = {15'h0, serial_out_oe, serial_out_oe & serial_out_line};
    // Idle pins at time zero
    initial
    begin
        chip_select = 1'b0;
        serial_clock_in = 1'b0;
        serial_in_line = 1'b0;
        res_valid = 1'b0;
        res_val = '0;
    end
    // ========================================
    // Tasks
    // ========================================
    task tick(input int n);
        repeat (n) @(posedge clock);
        #2;
    endtask : tick
    // One-cycle result strobe for the bench monitor
    task report(input logic [16:0] v);
        res_val = v;
        res_valid = 1'b1;
        tick(1);
        res_valid = 1'b0;
    endtask : report
    // Data set up 4 cycles before the rise; output sampled late in the high phase
    task shift(input logic [31:0] bits, input int n, output logic [31:0] got);
        got = '0;
        for (int i = n - 1; i >= 0; i--)
        begin
            serial_in_line = bits[i];
            tick(4);
            serial_clock_in = 1'b1;
            tick(5);
            got = {got[30:0], seen};
            serial_clock_in = 1'b0;
            tick(4);
        end
    endtask : shift
    // Select, shift, optional stray rise, then deselect
    task frame(input logic [31:0] bits, input int n, input logic late, output logic [31:0] got);
        logic [31:0] junk;
        chip_select = 1'b1;
        tick(4);
        shift(bits, n, got);
        if (late)
            shift(32'h0, 1, junk);
        chip_select = 1'b0;
        tick(6);
    endtask : frame
    // Busy, then ready, then release before the line is reused
    task poll(input int wait_n);
        logic [31:0] junk;
        chip_select = 1'b1;
        tick(6);
        report(st);
        tick(wait_n);
        report(st);
        shift(32'h1, 1, junk);
        report(st);
        chip_select = 1'b0;
        tick(6);
    endtask : poll
endmodule : sep_host

/* File: verif/serial_eeprom_command_port_test.sv */
// Purpose: Self-checking bench for the serial EEPROM command port.
// Assumes: Program cycle shortened to 20 clocks; array starts erased.
// Notes:   Expected words come from a reference array kept here.
module serial_eeprom_command_port_test;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int PROG = 20;
    logic clock = 1'b0;
    logic rstn;
    logic word_width_select;
    logic chip_select, serial_clock_in, serial_in_line, serial_out_line, serial_out_oe, res_valid;
    logic [16:0] res_val;
    logic [15:0] mem [64];
    logic wen = 1'b0;
    logic [31:0] seed = 32'h18A0;
    logic [31:0] r;
    logic [31:0] junk;
    logic [16:0] q [$];
    int fails = 0;
    int comparisons = 0;
    // ========================================
    // Clock and instances
    // ========================================
    always #12.5 clock = ~clock;
    sep_port #(.PROG_CYCLES(PROG)) dut (.clock(clock), .rstn(rstn), .chip_select(chip_select),
        .serial_clock_in(serial_clock_in), .serial_in_line(serial_in_line),
        .word_width_select(word_width_select), .serial_out_line(serial_out_line), .serial_out_oe(serial_out_oe));
    sep_host h (.clock(clock), .chip_select(chip_select), .serial_clock_in(serial_clock_in),
        .serial_in_line(serial_in_line), .serial_out_line(serial_out_line), .serial_out_oe(serial_out_oe),
        .res_valid(res_valid), .res_val(res_val));
    // ========================================
    // Checking
    // ========================================
    task check(input string what, input logic [16:0] exp, input logic [16:0] got);
        comparisons++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // Oldest note pairs with each reported result
    always @(posedge clock)
        if (res_valid === 1'b1)
            check("host result", (q.size() > 0) ? q.pop_front() : 17'h1FFFF, res_val);
    task tally_and_finish();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    // ========================================
    // Operations with reference model
    // ========================================
    task op(input logic [1:0] opc, input logic [5:0] a, input logic [15:0] d, input logic late);
        logic [31:0] got;
        logic ext;
        logic dat;
        logic prog;
        ext = (opc == sep_pkg::OPC_EXT);
        dat = (opc == sep_pkg::OPC_WRITE) || (ext && a[5:4] == sep_pkg::EXT_FILL_ALL);
        prog = wen && !late && !(ext && a[5:4] inside {sep_pkg::EXT_ENABLE, sep_pkg::EXT_DISABLE});
        if (dat)
            h.frame({7'h0, 1'b1, opc, a, d}, 25, late, got);
        else
            h.frame({23'h0, 1'b1, opc, a}, 9, late, got);
        if (ext && a[5:4] inside {sep_pkg::EXT_ENABLE, sep_pkg::EXT_DISABLE})
            wen = (a[5:4] == sep_pkg::EXT_ENABLE);
        for (int i = 0; i < 64; i++)
            if (prog && (ext || i == a))
                mem[i] = dat ? d : 16'hFFFF;
        if (prog)
        begin
            q.push_back(17'h2);
            q.push_back(17'h3);
            q.push_back(17'h0);
            h.poll(PROG + 8);
        end
    endtask : op
    task ext(input logic [1:0] sel, input logic [15:0] d);
        op(sep_pkg::OPC_EXT, {sel, 4'h0}, d, 1'b0);
    endtask : ext
    task rd(input logic [5:0] a, input int lz);
        logic [31:0] got;
        q.push_back({1'b0, mem[a]});
        h.frame({7'h0, 1'b1, sep_pkg::OPC_READ, a, 16'h0}, 25 + lz, 1'b0, got);
        h.report(got[16:0]);
    endtask : rd
    // Byte organization: address bit 0 picks the half
    task rdb(input logic [6:0] a);
        logic [31:0] got;
        q.push_back({9'h0, a[0] ? mem[a[6:1]][15:8] : mem[a[6:1]][7:0]});
        h.frame({14'h0, 1'b1, sep_pkg::OPC_READ, a, 8'h0}, 18, 1'b0, got);
        h.report({8'h0, got[8:0]});
    endtask : rdb
    // ========================================
    // Main sequence
    // ========================================
    initial
    begin
        rstn = 1'b0;
        word_width_select = 1'b1;
        for (int i = 0; i < 64; i++)
            mem[i] = 16'hFFFF;
        repeat (8) @(posedge clock);
        #2;
        rstn = 1'b1;
        h.tick(sep_pkg::POWERUP_TO_READ_CYCLES);
        op(sep_pkg::OPC_WRITE, 6'h05, 16'h1234, 1'b0);
        rd(6'h05, 0);
        ext(sep_pkg::EXT_ENABLE, 16'h0);
        repeat (4)
        begin
            r = rnd();
            op(sep_pkg::OPC_WRITE, r[5:0], r[31:16], 1'b0);
            rd(r[5:0], 0);
        end
        // Overlapping patterns expose a missing auto-clear
        op(sep_pkg::OPC_WRITE, 6'h3F, 16'h0F0F, 1'b0);
        op(sep_pkg::OPC_WRITE, 6'h3F, 16'hF0F0, 1'b0);
        rd(6'h3F, 0);
        op(sep_pkg::OPC_ERASE, 6'h3F, 16'h0, 1'b0);
        rd(6'h3F, 0);
        r = rnd();
        op(sep_pkg::OPC_WRITE, 6'h00, r[15:0], 1'b1);
        rd(6'h00, 0);
        h.frame({7'h0, 1'b1, sep_pkg::OPC_WRITE, 6'h00, r[15:0]} >> 8, 17, 1'b0, junk);
        rd(6'h00, 3);
        ext(sep_pkg::EXT_FILL_ALL, r[31:16]);
        rd(r[21:16], 0);
        rd(6'h3F, 0);
        ext(sep_pkg::EXT_DISABLE, 16'h0);
        ext(sep_pkg::EXT_CLEAR_ALL, 16'h0);
        op(sep_pkg::OPC_ERASE, 6'h3F, 16'h0, 1'b0);
        rd(6'h3F, 0);
        ext(sep_pkg::EXT_ENABLE, 16'h0);
        ext(sep_pkg::EXT_CLEAR_ALL, 16'h0);
        rd(r[27:22], 0);
        op(sep_pkg::OPC_WRITE, 6'h12, 16'hA55A, 1'b0);
        word_width_select = 1'b0;
        h.tick(4);
        h.frame({14'h0, 1'b1, sep_pkg::OPC_WRITE, 7'h25, 8'hC3}, 18, 1'b0, junk);
        mem[6'h12][15:8] = 8'hC3;
        q.push_back(17'h2);
        q.push_back(17'h3);
        q.push_back(17'h0);
        h.poll(PROG + 8);
        rdb(7'h24);
        rdb(7'h25);
        tally_and_finish();
    end
    // Watchdog well past the expected run length
    initial
    begin
        #(25 * 100000);
        fails++;
        tally_and_finish();
    end
endmodule : serial_eeprom_command_port_test
